// ==== verilog/sgcp_master.sv ====
// Bus master end: sends one 8-bit frame per request, holding the strobe low during it and raising it at the end.
// Assumes one system clock; makes the link clock by division.
`timescale 1ns/1ps
`include "sgcp_defs.svh"

module sgcp_master (
    // System
    input wire logic clk,
    input wire logic rstn,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_pdn,
    input wire sgcp_pkg::sgcp_gain_t req_gain,
    // Link
    sgcp_if.master link
);
    sgcp_pkg::sgcp_state_e state, next_state;
    logic [`SGCP_DIV_W-1:0] div, next_div;
    logic [`SGCP_BITCNT_W-1:0] bits, next_bits;
    sgcp_pkg::sgcp_frame_t sh, next_sh;
    logic sclk, next_sclk;
    logic strobe, next_strobe;

    assign req_ready = (state == sgcp_pkg::SGCP_IDLE);
    assign link.sclk = sclk;
    assign link.sdata = sh[`SGCP_FRAME_BITS-1];
    assign link.load_latch_strobe = strobe;

    // Frame sequencer: half periods of SGCP_HALF_CYC + 1 cycles
    always_comb begin
        next_state = state;
        next_div = div;
        next_bits = bits;
        next_sh = sh;
        next_sclk = sclk;
        next_strobe = strobe;
        if (div != '0) begin
            next_div = div - 1'b1;
        end
        unique case (state)
            sgcp_pkg::SGCP_IDLE: begin
                if (req_valid) begin
                    next_sh = {req_pdn, 1'b0, req_gain};
                    next_strobe = 1'b0;
                    next_bits = '0;
                    next_div = `SGCP_DIV_W'(`SGCP_HALF_CYC);
                    next_state = sgcp_pkg::SGCP_LOW;
                end
            end
            sgcp_pkg::SGCP_LOW: begin
                if (div == '0) begin
                    next_sclk = 1'b1;
                    next_div = `SGCP_DIV_W'(`SGCP_HALF_CYC);
                    next_state = sgcp_pkg::SGCP_HIGH;
                end
            end
            sgcp_pkg::SGCP_HIGH: begin
                if (div == '0) begin
                    next_sclk = 1'b0;
                    next_sh = {sh[`SGCP_FRAME_BITS-2:0], 1'b0};
                    next_bits = bits + 1'b1;
                    next_div = `SGCP_DIV_W'(`SGCP_HALF_CYC);
                    if (bits == `SGCP_BITCNT_W'(`SGCP_FRAME_BITS - 1)) begin
                        next_state = sgcp_pkg::SGCP_LOAD;
                    end else begin
                        next_state = sgcp_pkg::SGCP_LOW;
                    end
                end
            end
            sgcp_pkg::SGCP_LOAD: begin
                if (div == '0) begin
                    next_strobe = 1'b1;
                    next_state = sgcp_pkg::SGCP_IDLE;
                end
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= sgcp_pkg::SGCP_IDLE;
            div <= '0;
            bits <= '0;
            sh <= '0;
            sclk <= 1'b0;
            strobe <= 1'b1;
        end else begin
            state <= next_state;
            div <= next_div;
            bits <= next_bits;
            sh <= next_sh;
            sclk <= next_sclk;
            strobe <= next_strobe;
        end
    end
endmodule // sgcp_master

// ==== verilog/sgcp_defs.svh ====
// Constants for the serial gain control port: frame layout, defaults, timing.
// Assumes inclusion by bare name from the package and the two ends.
`ifndef SGCP_DEFS_SVH
`define SGCP_DEFS_SVH

// Frame layout
`define SGCP_FRAME_BITS 8
`define SGCP_GAIN_BITS 6
`define SGCP_PDN_POS 7
`define SGCP_SPARE_POS 6
`define SGCP_GAIN_MSB 5
`define SGCP_GAIN_LSB 0
`define SGCP_BITCNT_W 4

// Gain law: nominal gain in quarter dB is base plus code
`define SGCP_GAIN_BASE_QDB 8'h28
`define SGCP_GAIN_QDB_W 8

// Power-on default: 17.75 dB is code 31
`define SGCP_GAIN_RESET 6'h1F
`define SGCP_PDN_RESET 1'b0

// Timing: clock 25 MHz, link clock at most 1 MHz
`define SGCP_CLK_KHZ 25000
`define SGCP_LINK_MAX_KHZ 1000
`define SGCP_HALF_CYC ((`SGCP_CLK_KHZ + 2 * `SGCP_LINK_MAX_KHZ - 1) / (2 * `SGCP_LINK_MAX_KHZ))
`define SGCP_DIV_W 5

`endif

// ==== verilog/sgcp_pkg.sv ====
// Types shared by both ends of the serial gain control port.
// Assumes sgcp_defs.svh on the include path.
`include "sgcp_defs.svh"

package sgcp_pkg;
    typedef logic [`SGCP_GAIN_BITS-1:0] sgcp_gain_t;
    typedef logic [`SGCP_FRAME_BITS-1:0] sgcp_frame_t;
    typedef logic [`SGCP_GAIN_QDB_W-1:0] sgcp_qdb_t;

    typedef enum logic [1:0] {
        SGCP_IDLE = 2'b00,
        SGCP_LOW = 2'b01,
        SGCP_HIGH = 2'b10,
        SGCP_LOAD = 2'b11
    } sgcp_state_e;
endpackage

// ==== verilog/sgcp_if.sv ====
// Three-wire link between master and gain port, plus the daisy-chain output.
// Assumes both ends are clocked by the same system clock in the bench.
`timescale 1ns/1ps

interface sgcp_if;
    logic sclk;
    logic sdata;
    logic load_latch_strobe;
    logic sdout;

    modport master (output sclk, output sdata, output load_latch_strobe, input sdout);
    modport device (input sclk, input sdata, input load_latch_strobe, output sdout);
endinterface

// ==== verilog/sgcp_device.sv ====
// Gain port end: samples link pins, shifts on rising link clock, latches on strobe.
// Assumes link pins are asynchronous; two flops before use.
`timescale 1ns/1ps
`include "sgcp_defs.svh"

module sgcp_device (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Link
    sgcp_if.device link,
    // Applied setting
    output sgcp_pkg::sgcp_gain_t gain_code,
    output sgcp_pkg::sgcp_qdb_t gain_qdb,
    output logic power_down
);
    logic [2:0] sync1, sync2, next_sync1, next_sync2;
    logic sclk_d, next_sclk_d;
    logic le_d, next_le_d;
    sgcp_pkg::sgcp_frame_t chain, next_chain;
    logic sdout, next_sdout;
    sgcp_pkg::sgcp_gain_t next_gain_code;
    sgcp_pkg::sgcp_qdb_t next_gain_qdb;
    logic next_power_down;
    logic rise, fall, le_rise;

    assign link.sdout = sdout;

    // Two-flop synchronisers and edge history
    always_comb begin
        next_sync1 = {link.load_latch_strobe, link.sdata, link.sclk};
        next_sync2 = sync1;
        next_sclk_d = sync2[0];
        next_le_d = sync2[2];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            sclk_d <= 1'b0;
            le_d <= 1'b1;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sclk_d <= next_sclk_d;
            le_d <= next_le_d;
        end
    end

    // Edge detects on synchronised pins
    assign rise = sync2[0] & ~sclk_d;
    assign fall = ~sync2[0] & sclk_d;
    assign le_rise = sync2[2] & ~le_d;

    // Chain, output stage and latched setting
    always_comb begin
        next_chain = chain;
        next_sdout = sdout;
        next_gain_code = gain_code;
        next_gain_qdb = gain_qdb;
        next_power_down = power_down;
        if (!sync2[2] && rise) begin
            next_chain = {chain[`SGCP_FRAME_BITS-2:0], sync2[1]};
        end
        if (!sync2[2] && fall) begin
            next_sdout = chain[`SGCP_FRAME_BITS-1];
        end
        if (le_rise) begin
            next_power_down = chain[`SGCP_PDN_POS];
            next_gain_code = chain[`SGCP_GAIN_MSB:`SGCP_GAIN_LSB];
            next_gain_qdb = `SGCP_GAIN_BASE_QDB
                + {2'h0, chain[`SGCP_GAIN_MSB:`SGCP_GAIN_LSB]};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chain <= '0;
            sdout <= 1'b0;
            gain_code <= `SGCP_GAIN_RESET;
            gain_qdb <= `SGCP_GAIN_BASE_QDB + {2'h0, `SGCP_GAIN_RESET};
            power_down <= `SGCP_PDN_RESET;
        end else begin
            chain <= next_chain;
            sdout <= next_sdout;
            gain_code <= next_gain_code;
            gain_qdb <= next_gain_qdb;
            power_down <= next_power_down;
        end
    end
endmodule // sgcp_device

// ==== tb/sgcp_monitor.sv ====
// Link checker: timing and framing of the three wires and the chain output.
// Assumes the bench hands it the link signals and the system clock.
`timescale 1ns/1ps

module sgcp_monitor (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Link
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_latch_strobe,
    input wire logic sdout
);
    logic [4:0] hcnt;
    logic [4:0] next_hcnt;
    logic [3:0] rcnt;
    logic [3:0] next_rcnt;
    logic sclk_d;
    logic next_sclk_d;

    // Cycles since sclk moved, rises within a frame
    always_comb begin
        next_hcnt = (sclk != sclk_d) ? 5'h00 : ((hcnt == 5'h1F) ? hcnt : hcnt + 5'h01);
        next_rcnt = load_latch_strobe ? 4'h0 : rcnt + {3'h0, sclk & ~sclk_d};
        next_sclk_d = sclk;
    end

    // Helper registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hcnt <= 5'h1F;
            rcnt <= 4'h0;
            sclk_d <= 1'b0;
        end else begin
            hcnt <= next_hcnt;
            rcnt <= next_rcnt;
            sclk_d <= next_sclk_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_strobe_clk_low: assert property (load_latch_strobe |-> !sclk)
        else $error("sclk high while strobe high");
    a_half_period: assert property ((sclk != sclk_d) |-> hcnt >= 5'h0C)
        else $error("sclk half period too short");
    a_eight_rises: assert property ($rose(load_latch_strobe) |-> rcnt == 4'h8)
        else $error("strobe rose without eight clock rises");
    a_latch_setup: assert property ($rose(load_latch_strobe) |-> !sclk && hcnt >= 5'h0C)
        else $error("strobe rose too soon after sclk");
    a_data_hold_high: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("sdata moved while sclk high");
    a_data_setup: assert property ($rose(sclk) |-> sdata == $past(sdata, 2))
        else $error("sdata moved just before sclk rise");
    a_out_on_fall: assert property ($changed(sdout) |-> !sclk && !$past(sclk, 2))
        else $error("sdout moved outside falling edge");
    a_first_quiet: assert property ($fell(load_latch_strobe) |=> !sclk [*8])
        else $error("sclk rose too soon after strobe fell");
endmodule // sgcp_monitor

// ==== tb/serial_gain_control_port_test.sv ====
// Bench: master and gain port joined by one link, frames sent and checked.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ps

module serial_gain_control_port_test;
    logic clk;
    logic rstn;
    logic req_valid;
    logic req_ready;
    logic req_pdn;
    logic power_down;
    sgcp_pkg::sgcp_gain_t req_gain;
    sgcp_pkg::sgcp_gain_t gain_code;
    sgcp_pkg::sgcp_gain_t exp_code;
    sgcp_pkg::sgcp_qdb_t gain_qdb;
    logic exp_pdn;
    int miscompares;
    int tests_run;
    int cycles = 0;
    sgcp_if sgcp_if_i ();
    sgcp_master sgcp_master_i (.clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req_pdn(req_pdn), .req_gain(req_gain), .link(sgcp_if_i.master));
    sgcp_device sgcp_device_i (.clk(clk), .rstn(rstn), .link(sgcp_if_i.device),
        .gain_code(gain_code), .gain_qdb(gain_qdb), .power_down(power_down));
    sgcp_monitor sgcp_monitor_i (.clk(clk), .rstn(rstn), .sclk(sgcp_if_i.sclk),
        .sdata(sgcp_if_i.sdata), .load_latch_strobe(sgcp_if_i.load_latch_strobe),
        .sdout(sgcp_if_i.sdout));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Applied setting against expectation
    task automatic check_all();
        check("gain_code", {2'h0, gain_code}, {2'h0, exp_code});
        check("gain_qdb", gain_qdb, 8'h28 + {2'h0, exp_code});
        check("power_down", {7'h00, power_down}, {7'h00, exp_pdn});
    endtask

    // One frame through the master, then the latched result
    task automatic send(input logic pdn, input sgcp_pkg::sgcp_gain_t code);
        req_pdn <= pdn;
        req_gain <= code;
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        repeat (100) @(posedge clk);
        check_all();
        while (req_ready !== 1'b1) @(posedge clk);
        repeat (4) @(posedge clk);
        exp_code = code;
        exp_pdn = pdn;
        check_all();
        check("sdout", {7'h00, sgcp_if_i.sdout}, {7'h00, pdn});
    endtask

    // Reset pulse and power-on setting
    task automatic reset_check();
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        exp_code = 6'h1F;
        exp_pdn = 1'b0;
        check_all();
        check("sdout", {7'h00, sgcp_if_i.sdout}, 8'h00);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_pdn = 1'b0;
        req_gain = 6'h00;
        miscompares = 0;
        tests_run = 0;
        reset_check();
        send(1'b0, 6'h00);
        send(1'b0, 6'h01);
        send(1'b0, 6'h3E);
        send(1'b0, 6'h3F);
        send(1'b0, 6'h2A);
        send(1'b1, 6'h0C);
        send(1'b0, 6'h33);
        reset_check();
        final_report();
    end
endmodule // serial_gain_control_port_test
